// >>> pin_mux_pkg.sv
/*
 * Shared constants for the port pin function multiplexer: pin counts,
 * port B line 0 function codes, reset values and synchroniser depth.
 * Assumes nothing of its surroundings; it is compiled before the mux.
 */
`default_nettype none
package pin_mux_pkg;

   // ------------------------------------------------------------------
   // Sizes
   // ------------------------------------------------------------------
   localparam int PA_LINES   = 4;     // Port A lines handled here
   localparam int SYNC_DEPTH = 2;     // Flops on every pin input

   // ------------------------------------------------------------------
   // Port B line 0 function select (Gray along gpio, timer, converter)
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      PB0_GPIO  = 2'h0,
      PB0_TIMER = 2'h1,
      PB0_CONV  = 2'h3
   } pb0_mode_e;

   // ------------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------------
   localparam logic       RST_BIT  = 1'h0;    // Any single output bit but slave select
   localparam logic [3:0] RST_NIB  = 4'h0;    // Any port A vector
   localparam logic       RST_SS_N = 1'h1;    // Slave select idles high

endpackage
`default_nettype wire

// >>> port_pin_function_mux.sv
/*
 * Port pin function multiplexer for port B line 0 and port A lines 0..3.
 * Assumes the GPIO, timer, converter, SPI and wake-up logic sit on CLK_I,
 * and that the pad cells resolve the wire from output and output enable.
 */
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------------------------------------------
// ---------------------------------------------------------------------
module port_pin_function_mux #(
   parameter int PA_W = pin_mux_pkg::PA_LINES   // Port A lines, fixed map
) (
   input  wire logic              CLK_I,            // System clock 20 MHz
   input  wire logic              RESETN_I,         // Async reset, low
   // Port B line 0 pad
   input  wire logic              PB0_PIN_I,        // Pad level
   output logic                   PB0_PIN_O,        // Pad drive value
   output logic                   PB0_PIN_OE_O,     // Pad drive enable
   output logic                   PB0_PULLUP_O,     // Pullup device on
   output logic                   PB0_CONV_EN_O,    // Analog path to converter_input3
   // Port B line 0 configuration and GPIO data
   input  wire logic [1:0]        PB0_MODE_I,       // Function select code
   input  wire logic              PB0_DIR_OUT_I,    // GPIO direction, 1 = out
   input  wire logic              PB0_DATA_I,       // GPIO output value
   input  wire logic              PB0_PULLUP_EN_I,  // Pullup request
   output logic                   PB0_IN_O,         // GPIO read value
   // Timer channel 0 (timer_channel0_pin)
   input  wire logic              TMR_CH0_O_I,      // Timer compare output
   input  wire logic              TMR_CH0_OE_I,     // Timer drives the pin
   output logic                   TMR_CH0_IN_O,     // Timer capture input
   // Port A pads
   input  wire logic [PA_W-1:0]   PA_PIN_I,         // Pad levels
   output logic [PA_W-1:0]        PA_PIN_O,         // Pad drive values
   output logic [PA_W-1:0]        PA_PIN_OE_O,      // Pad drive enables
   output logic [PA_W-1:0]        PA_PULLUP_O,      // Pullup devices on
   output logic [PA_W-1:0]        PA_PULLDN_O,      // Pulldown devices on
   // Port A configuration and GPIO data
   input  wire logic [PA_W-1:0]   PA_DIR_OUT_I,     // GPIO direction, 1 = out
   input  wire logic [PA_W-1:0]   PA_DATA_I,        // GPIO output values
   input  wire logic [PA_W-1:0]   PA_PULL_EN_I,     // Pull device request
   input  wire logic [PA_W-1:0]   PA_PULL_DN_I,     // 1 = pulldown, 0 = pullup
   input  wire logic [PA_W-1:0]   PA_WAKE_EN_I,     // Wake-up capability on
   output logic [PA_W-1:0]        PA_IN_O,          // GPIO read values
   output logic [PA_W-1:0]        WAKE_KEY_O,       // wake_key_bit3..0 levels
   // Client SPI
   input  wire logic              SPI_EN_I,         // Client SPI enabled
   input  wire logic              SPI_MISO_I,       // Serial data to host
   input  wire logic              SPI_MISO_OE_I,    // SPI drives MISO
   output logic                   SPI_MOSI_O,       // Serial data from host
   output logic                   SPI_SCLK_O,       // Serial clock from host
   output logic                   SPI_SS_N_O        // Slave select, low
);

   // ------------------------------------------------------------------
   // Elaboration check
   // ------------------------------------------------------------------
   // The SPI and wake mapping is fixed to four lines
   if (PA_W != pin_mux_pkg::PA_LINES) begin : g_bad_width
      $error("PA_W must be 4");
   end

   // ------------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------------
   logic [PA_W-1:0]  pa_meta_r;
   logic [PA_W-1:0]  pa_sync_r;
   logic             pb0_meta_r;
   logic             pb0_sync_r;

   // Two flops; only the second is read by any logic
   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         pa_meta_r  <= pin_mux_pkg::RST_NIB;
         pa_sync_r  <= pin_mux_pkg::RST_NIB;
         pb0_meta_r <= pin_mux_pkg::RST_BIT;
         pb0_sync_r <= pin_mux_pkg::RST_BIT;
      end else begin
         pa_meta_r  <= PA_PIN_I;
         pa_sync_r  <= pa_meta_r;
         pb0_meta_r <= PB0_PIN_I;
         pb0_sync_r <= pb0_meta_r;
      end
   end

   // ------------------------------------------------------------------
   // Port B line 0
   // ------------------------------------------------------------------
   logic pb0_gpio;
   logic pb0_tmr;
   logic pb0_conv;

   // Unknown codes fall back to GPIO so the pin is never left orphaned
   assign pb0_tmr  = (PB0_MODE_I == pin_mux_pkg::PB0_TIMER);
   assign pb0_conv = (PB0_MODE_I == pin_mux_pkg::PB0_CONV);
   assign pb0_gpio = !pb0_tmr && !pb0_conv;

   // Drive, pull and analog path; converter mode frees the pad entirely
   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         PB0_PIN_O     <= pin_mux_pkg::RST_BIT;
         PB0_PIN_OE_O  <= pin_mux_pkg::RST_BIT;
         PB0_PULLUP_O  <= pin_mux_pkg::RST_BIT;
         PB0_CONV_EN_O <= pin_mux_pkg::RST_BIT;
      end else begin
         PB0_PIN_O     <= pb0_tmr ? TMR_CH0_O_I : PB0_DATA_I;
         PB0_PIN_OE_O  <= (pb0_gpio && PB0_DIR_OUT_I) ||
                          (pb0_tmr && TMR_CH0_OE_I);
         // Pullup is pointless on a driven or analog pin, so it drops there
         PB0_PULLUP_O  <= PB0_PULLUP_EN_I && !pb0_conv &&
                          !(pb0_gpio && PB0_DIR_OUT_I) &&
                          !(pb0_tmr && TMR_CH0_OE_I);
         PB0_CONV_EN_O <= pb0_conv;
      end
   end

   // Read paths; the timer sees the pin only while it owns it
   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         PB0_IN_O     <= pin_mux_pkg::RST_BIT;
         TMR_CH0_IN_O <= pin_mux_pkg::RST_BIT;
      end else begin
         PB0_IN_O     <= pb0_conv ? pin_mux_pkg::RST_BIT : pb0_sync_r;
         TMR_CH0_IN_O <= pb0_tmr && pb0_sync_r;
      end
   end

   // ------------------------------------------------------------------
   // Port A lines
   // ------------------------------------------------------------------
   logic [PA_W-1:0] pa_gpio_oe;
   logic [PA_W-1:0] pa_gpio_mask;

   // Under SPI all four lines leave the GPIO role
   assign pa_gpio_mask = SPI_EN_I ? pin_mux_pkg::RST_NIB : {PA_W{1'b1}};
   assign pa_gpio_oe   = PA_DIR_OUT_I & pa_gpio_mask;

   // Pad drive: only MISO is an output under SPI
   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         PA_PIN_O    <= pin_mux_pkg::RST_NIB;
         PA_PIN_OE_O <= pin_mux_pkg::RST_NIB;
      end else begin
         PA_PIN_O    <= SPI_EN_I ? {1'b0, SPI_MISO_I, 2'b00} : PA_DATA_I;
         PA_PIN_OE_O <= SPI_EN_I ? {1'b0, SPI_MISO_OE_I, 2'b00} : pa_gpio_oe;
      end
   end

   // Pulls: pulldown needs wake-up enabled; SPI owns the lines so no pulls
   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         PA_PULLUP_O <= pin_mux_pkg::RST_NIB;
         PA_PULLDN_O <= pin_mux_pkg::RST_NIB;
      end else begin
         PA_PULLUP_O <= PA_PULL_EN_I & ~PA_PULL_DN_I & ~pa_gpio_oe & pa_gpio_mask;
         PA_PULLDN_O <= PA_PULL_EN_I & PA_PULL_DN_I & PA_WAKE_EN_I &
                        ~pa_gpio_oe & pa_gpio_mask;
      end
   end

   // GPIO reads and wake key bits; each wake bit follows its own line
   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         PA_IN_O    <= pin_mux_pkg::RST_NIB;
         WAKE_KEY_O <= pin_mux_pkg::RST_NIB;
      end else begin
         PA_IN_O    <= pa_sync_r & pa_gpio_mask;
         WAKE_KEY_O <= pa_sync_r & PA_WAKE_EN_I & pa_gpio_mask;
      end
   end

   // SPI inputs; idle values while disabled keep the SPI core quiet
   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         SPI_MOSI_O <= pin_mux_pkg::RST_BIT;
         SPI_SCLK_O <= pin_mux_pkg::RST_BIT;
         SPI_SS_N_O <= pin_mux_pkg::RST_SS_N;
      end else begin
         SPI_MOSI_O <= SPI_EN_I && pa_sync_r[3];
         SPI_SCLK_O <= SPI_EN_I && pa_sync_r[1];
         SPI_SS_N_O <= !SPI_EN_I || pa_sync_r[0];
      end
   end

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RESETN_I);

   // A pad level held for three edges reaches the outputs
   sequence s_pa3_high;
      PA_PIN_I[3] [*3];
   endsequence
   sequence s_pa0_low;
      !PA_PIN_I[0] [*3];
   endsequence

   a_pulldn_needs_wake: assert property (PA_PULLDN_O != 4'h0 |->
      ($past(PA_WAKE_EN_I) & PA_PULLDN_O) == PA_PULLDN_O)
      else $error("Pulldown on without wake-up enable");
   a_pull_exclusive: assert property ((PA_PULLDN_O & PA_PULLUP_O) == 4'h0)
      else $error("Pullup and pulldown on together");
   a_wake3_follows: assert property (s_pa3_high ##0 (PA_WAKE_EN_I[3] && !SPI_EN_I) [*3]
      |=> WAKE_KEY_O[3])
      else $error("Wake bit 3 missed its pin");
   a_wake2_gated: assert property (WAKE_KEY_O[2] |-> $past(PA_WAKE_EN_I[2] && !SPI_EN_I))
      else $error("Wake bit 2 set while disabled");
   a_mosi_follows: assert property (s_pa3_high ##0 SPI_EN_I [*3] |=> SPI_MOSI_O)
      else $error("MOSI did not follow its pin");
   a_miso_drive: assert property (SPI_EN_I && SPI_MISO_OE_I |=>
      PA_PIN_OE_O == 4'h4 && PA_PIN_O[2] == $past(SPI_MISO_I))
      else $error("MISO not driven on line 2");
   a_sclk_idle: assert property (!SPI_EN_I |=> !SPI_SCLK_O && SPI_SS_N_O)
      else $error("SPI inputs active while disabled");
   a_ss_low: assert property (s_pa0_low ##0 SPI_EN_I [*3] |=> !SPI_SS_N_O)
      else $error("Slave select not taken from line 0");
   a_gpio_back: assert property ($fell(SPI_EN_I) ##0 PA_DIR_OUT_I == 4'hF |=>
      PA_PIN_OE_O == 4'hF)
      else $error("GPIO drive not restored after SPI");
   a_pb0_conv_free: assert property (PB0_CONV_EN_O |-> !PB0_PIN_OE_O && !PB0_PULLUP_O)
      else $error("Converter pin still driven or pulled");
   a_pb0_timer: assert property (PB0_MODE_I == 2'h1 && TMR_CH0_OE_I |=>
      PB0_PIN_OE_O && PB0_PIN_O == $past(TMR_CH0_O_I))
      else $error("Timer not routed to port B line 0");
   a_pb0_pullup: assert property (PB0_MODE_I == 2'h0 && !PB0_DIR_OUT_I |=>
      PB0_PULLUP_O == $past(PB0_PULLUP_EN_I) && !PB0_PIN_OE_O)
      else $error("Port B line 0 pullup not under control");

endmodule
`default_nettype wire

// >>> pad_world.sv
/*
 * Model of the wires outside a group of pads: device drive, outside drive,
 * pull devices and floating lines.
 * Assumes the testbench never drives a line that the device drives.
 */
`timescale 1ns/10ps
`default_nettype none
module pad_world #(
   parameter int N = 4                      // Lines modelled
) (
   input  wire logic         clk_i,         // System clock
   input  wire logic [N-1:0] oe_i,          // Device drives line
   input  wire logic [N-1:0] val_i,         // Device drive value
   input  wire logic [N-1:0] pu_i,          // Pullup on
   input  wire logic [N-1:0] pd_i,          // Pulldown on
   input  wire logic [N-1:0] ext_en_i,      // Outside drives line
   input  wire logic [N-1:0] ext_i,         // Outside drive value
   output logic [N-1:0]      pin_o          // Resolved wire level
);
   // ------------------------------------------------------------------
   // Wire resolution
   // ------------------------------------------------------------------
   // A floating line toggles, so a missing pull never reads as a match
   logic [N-1:0] float_r = '0;
   always_ff @(posedge clk_i) begin
      float_r <= ~float_r;
   end
   // Strong drive first, then the pull devices
   always_comb begin
      for (int i = 0; i < N; i++) begin
         pin_o[i] = oe_i[i] ? val_i[i] : ext_en_i[i] ? ext_i[i] :
                    pu_i[i] ? 1'h1 : pd_i[i] ? 1'h0 : float_r[i];
      end
   end
endmodule
`default_nettype wire

// >>> port_pin_function_mux_tb.sv
/*
 * Self-checking testbench for the port pin function mux.
 * Assumes inputs change at the falling edge and four cycles cover latency.
 */
`timescale 1ns/10ps
`default_nettype none
module port_pin_function_mux_tb;
   logic       CLK_I = 0, RESETN_I = 0, PB0_PIN_I, PB0_PIN_O, PB0_PIN_OE_O, PB0_PULLUP_O, PB0_CONV_EN_O, PB0_IN_O;
   logic [1:0] PB0_MODE_I = 0;
   logic       PB0_DIR_OUT_I = 0, PB0_DATA_I = 0, PB0_PULLUP_EN_I = 0, TMR_CH0_O_I = 0, TMR_CH0_OE_I = 0;
   logic       TMR_CH0_IN_O, SPI_EN_I = 0, SPI_MISO_I = 0, SPI_MISO_OE_I = 0, SPI_MOSI_O, SPI_SCLK_O, SPI_SS_N_O;
   logic       pb_ext_en = 0, pb_ext = 0;
   logic [3:0] PA_PIN_I, PA_PIN_O, PA_PIN_OE_O, PA_PULLUP_O, PA_PULLDN_O, PA_IN_O, WAKE_KEY_O;
   logic [3:0] PA_DIR_OUT_I = 0, PA_DATA_I = 0, PA_PULL_EN_I = 0, PA_PULL_DN_I = 0, PA_WAKE_EN_I = 0;
   logic [3:0] pa_ext_en = 0, pa_ext = 0;
   logic       miso_val = 1'h1;        // MISO data offered while SPI is on
   int         fail_count = 0, checked = 0;
   // 20 MHz system clock
   always #25 CLK_I = ~CLK_I;
   port_pin_function_mux u_dut (.CLK_I, .RESETN_I, .PB0_PIN_I, .PB0_PIN_O, .PB0_PIN_OE_O, .PB0_PULLUP_O,
      .PB0_CONV_EN_O, .PB0_MODE_I, .PB0_DIR_OUT_I, .PB0_DATA_I, .PB0_PULLUP_EN_I, .PB0_IN_O, .TMR_CH0_O_I,
      .TMR_CH0_OE_I, .TMR_CH0_IN_O, .PA_PIN_I, .PA_PIN_O, .PA_PIN_OE_O, .PA_PULLUP_O, .PA_PULLDN_O,
      .PA_DIR_OUT_I, .PA_DATA_I, .PA_PULL_EN_I, .PA_PULL_DN_I, .PA_WAKE_EN_I, .PA_IN_O, .WAKE_KEY_O,
      .SPI_EN_I, .SPI_MISO_I, .SPI_MISO_OE_I, .SPI_MOSI_O, .SPI_SCLK_O, .SPI_SS_N_O);
   pad_world #(.N(1)) u_pb (.clk_i(CLK_I), .oe_i(PB0_PIN_OE_O), .val_i(PB0_PIN_O), .pu_i(PB0_PULLUP_O),
      .pd_i(1'h0), .ext_en_i(pb_ext_en), .ext_i(pb_ext), .pin_o(PB0_PIN_I));
   pad_world #(.N(4)) u_pa (.clk_i(CLK_I), .oe_i(PA_PIN_OE_O), .val_i(PA_PIN_O), .pu_i(PA_PULLUP_O),
      .pd_i(PA_PULLDN_O), .ext_en_i(pa_ext_en), .ext_i(pa_ext), .pin_o(PA_PIN_I));
   // ------------------------------------------------------------------
   // Access tasks
   // ------------------------------------------------------------------
   task automatic check(input logic [3:0] seen, input logic [3:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Four cycles cover the three-edge pad path with margin
   task automatic pb(input logic [1:0] m, input logic d, v, pu, to, toe, xe, x);
      PB0_MODE_I = m;
      PB0_DIR_OUT_I = d;
      PB0_DATA_I = v;
      PB0_PULLUP_EN_I = pu;
      TMR_CH0_O_I = to;
      TMR_CH0_OE_I = toe;
      pb_ext_en = xe;
      pb_ext = x;
      repeat (4) @(negedge CLK_I);
   endtask
   task automatic pa(input logic [3:0] d, v, pe, pd, w, input logic spi, input logic [3:0] xe, x);
      PA_DIR_OUT_I = d;
      PA_DATA_I = v;
      PA_PULL_EN_I = pe;
      PA_PULL_DN_I = pd;
      PA_WAKE_EN_I = w;
      SPI_EN_I = spi;
      SPI_MISO_I = miso_val;
      SPI_MISO_OE_I = spi;
      pa_ext_en = xe;
      pa_ext = x;
      repeat (4) @(negedge CLK_I);
   endtask
   task summarize();
      $display("Comparisons %0d, mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // ------------------------------------------------------------------
   // Test sequence
   // ------------------------------------------------------------------
   initial begin
      repeat (2) @(negedge CLK_I);
      check({PB0_PIN_OE_O, PB0_PULLUP_O, PB0_CONV_EN_O, SPI_SS_N_O}, 4'h1);
      check(PA_PIN_OE_O | PA_PULLDN_O | WAKE_KEY_O, 4'h0);
      repeat (18) @(negedge CLK_I);
      RESETN_I = 1'h1;
      $display("test reset done");
      // Port B line 0 across all function codes
      pb(2'h0, 1, 1, 1, 0, 0, 0, 0);
      check({PB0_PIN_OE_O, PB0_PIN_O, PB0_PULLUP_O, PB0_CONV_EN_O}, 4'hC);
      pb(2'h0, 0, 0, 1, 0, 0, 1, 0);
      check({PB0_PIN_OE_O, PB0_PULLUP_O, PB0_IN_O, PB0_CONV_EN_O}, 4'h4);
      pb(2'h0, 0, 0, 1, 0, 0, 0, 0);
      check({PB0_PIN_OE_O, PB0_PULLUP_O, PB0_IN_O, PB0_CONV_EN_O}, 4'h6);
      pb(2'h1, 0, 1, 0, 0, 1, 0, 0);
      check({PB0_PIN_OE_O, PB0_PIN_O, TMR_CH0_IN_O, PB0_CONV_EN_O}, 4'h8);
      pb(2'h1, 0, 0, 0, 0, 0, 1, 1);
      check({PB0_PIN_OE_O, TMR_CH0_IN_O, PB0_CONV_EN_O, 1'h0}, 4'h4);
      pb(2'h3, 0, 0, 1, 0, 0, 1, 1);
      check({PB0_CONV_EN_O, PB0_IN_O, PB0_PULLUP_O, PB0_PIN_OE_O}, 4'h8);
      pb(2'h2, 0, 0, 0, 0, 0, 1, 1);
      check({PB0_CONV_EN_O, TMR_CH0_IN_O, PB0_IN_O, PB0_PIN_OE_O}, 4'h2);
      $display("test port_b done");
      // Port A pulls and wake bits, then the SPI takeover and release
      pa(4'hF, 4'h5, 4'h0, 4'h0, 4'h0, 0, 4'h0, 4'h0);
      check(PA_PIN_OE_O, 4'hF);
      check(PA_PIN_O, 4'h5);
      pa(4'h0, 4'h0, 4'hF, 4'hF, 4'h0, 0, 4'hF, 4'hE);
      check(PA_PULLDN_O | PA_PULLUP_O, 4'h0);
      pa(4'h0, 4'h0, 4'hF, 4'hF, 4'hF, 0, 4'hF, 4'hE);
      check(PA_PULLDN_O, 4'hF);
      check(WAKE_KEY_O, 4'hE);
      check(PA_IN_O, 4'hE);
      pa(4'h0, 4'h0, 4'hF, 4'h0, 4'hF, 0, 4'hF, 4'hE);
      check(PA_PULLUP_O, 4'hF);
      check(PA_PULLDN_O, 4'h0);
      pa(4'h0, 4'h0, 4'hF, 4'hF, 4'hF, 1, 4'hB, 4'hA);
      check(PA_PIN_OE_O, 4'h4);
      check(PA_PIN_O, 4'h4);
      check(PA_PULLUP_O | PA_PULLDN_O | WAKE_KEY_O | PA_IN_O, 4'h0);
      check({SPI_MOSI_O, 1'h0, SPI_SCLK_O, SPI_SS_N_O}, 4'hA);
      pa(4'h0, 4'h0, 4'hF, 4'hF, 4'hF, 0, 4'hB, 4'hA);
      check(PA_PULLDN_O, 4'hF);
      check(WAKE_KEY_O, 4'hA);
      check({PA_PIN_OE_O[2], SPI_MOSI_O, SPI_SCLK_O, SPI_SS_N_O}, 4'h1);
      // SPI again with opposite pin levels and MISO low, so tied-off paths show
      miso_val = 1'h0;
      pa(4'hF, 4'hF, 4'hF, 4'hF, 4'hF, 1, 4'hB, 4'h1);
      check(PA_PIN_OE_O, 4'h4);
      check(PA_PIN_O, 4'h0);
      check(PA_IN_O | WAKE_KEY_O, 4'h0);
      check({SPI_MOSI_O, 1'h0, SPI_SCLK_O, SPI_SS_N_O}, 4'h1);
      // SPI released while every line asks to drive: GPIO drive comes back
      pa(4'hF, 4'hA, 4'h0, 4'h0, 4'h0, 0, 4'h0, 4'h0);
      check(PA_PIN_OE_O, 4'hF);
      check(PA_PIN_O, 4'hA);
      $display("test port_a done");
      summarize();
   end
   // Watchdog: the sequence needs under 200 cycles
   initial begin
      #(2000 * 50);
      fail_count++;
      summarize();
   end
endmodule
`default_nettype wire
